// >>> verilog/sync_burst_sram_control.sv
// Purpose: Command decode, burst counter and byte-write decode of a sync burst SRAM
// Assumes: All control pins are synchronised to clk_in by two flops first
// Notes  : Write requests queue in a FIFO toward the array; a full FIFO stalls
//
// Overview of operation
// - Linear order adds one modulo four to the low address bits, wrapping.
// - Interleaved order XORs the start value with a 00..11 count.
// - Linear order when linear_order_n low, interleaved when high.
// - global_write_n low writes all four bytes regardless of lane inputs.
// - byte_write_n low writes the lanes whose enables are low, else read.
// - Read cycles enable output drivers on all four byte lanes.
// - Write cycles keep every data lane in high impedance.
// - Deselect with outputs off for the three chip enable cases.
// - Read burst starts on processor strobe, or controller strobe without write.
// - Controller strobe with write decode loads address, begins write burst.
// - With no strobe and advance low, step to next burst address.
// - With no strobe and advance high, hold current burst address.
// - Output enable is synchronised by two flops; it only gates drivers made active.
// - A dummy read advances the counter exactly like a normal read.
// - flowthru_sel_n low bypasses the output register, else pipelined.
// - Deselect pipelines one stage less than read; outputs turn off promptly.
`timescale 1ns/1ps
`include "sram_ctrl_defines.svh"
module sync_burst_sram_control #(
    parameter int ADDR_W     = `ADDR_W,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     sys_rst_in,
    // Synchronous control and address pins
    input  wire sram_ctrl_pkg::ctrl_in_t  ctrl_in,
    // Mode pins
    input  wire logic                     linear_order_n_in,
    input  wire logic                     flowthru_sel_n_in,
    // Output enable, synchronised by two flops
    input  wire logic                     output_en_n_in,
    // Data pins, split as input, output and enable per lane
    input  wire logic [`DATA_W-1:0]       dq_in,
    output logic [`DATA_W-1:0]            dq_out,
    output logic [`LANES-1:0]             dq_oe_out,
    // Array side: write queue
    output logic                          wr_valid_out,
    input  wire logic                     wr_ready_in,
    output sram_ctrl_pkg::mem_req_t       wr_req_out,
    // Array side: read address and returned data
    output logic [`ADDR_W-1:0]            rd_addr_out,
    output logic                          rd_en_out,
    input  wire logic [`DATA_W-1:0]       rd_data_in,
    // Block stalled because the write queue is full
    output logic                          stall_out
);
    import sram_ctrl_pkg::*;

    // ==========================================
    // Input synchronisers
    ctrl_in_t            ctrl_s1_reg, ctrl_s2_reg;
    logic [2:0]          mode_s1_reg, mode_s2_reg;
    logic [`DATA_W-1:0]  dq_s1_reg, dq_s2_reg;

    // Two flops for every pin from outside; only stage two is read
    always_ff @(posedge clk_in) begin
        ctrl_s1_reg <= ctrl_in;
        ctrl_s2_reg <= ctrl_s1_reg;
        mode_s1_reg <= {linear_order_n_in, flowthru_sel_n_in, output_en_n_in};
        mode_s2_reg <= mode_s1_reg;
        dq_s1_reg   <= dq_in;
        dq_s2_reg   <= dq_s1_reg;
    end

    logic linear_mode, flowthru_mode, oe_n_sync;
    assign linear_mode   = ~mode_s2_reg[2];
    assign flowthru_mode = ~mode_s2_reg[1];
    assign oe_n_sync     = mode_s2_reg[0];

    // ==========================================
    // Functions
    // lane write decode
    function automatic logic [`LANES-1:0] lane_decode(input ctrl_in_t c);
        if (!c.global_write_n) begin
            lane_decode = '1;
        end else if (!c.byte_write_n) begin
            lane_decode = ~c.lane_write_n;
        end else begin
            lane_decode = '0;
        end
    endfunction : lane_decode

    function automatic logic [1:0] burst_bits(input logic [1:0] start,
                                              input logic [1:0] cnt,
                                              input logic lin);
        burst_bits = lin ? 2'(start + cnt) : (start ^ cnt);
    endfunction : burst_bits

    // ==========================================
    // Command decode
    ctrl_in_t          c;
    logic              en_true, write_dec, stall;
    logic [`LANES-1:0] lanes;
    op_t               op;

    always_comb begin
        c         = ctrl_s2_reg;
        en_true   = c.chip_sel2 && !c.chip_sel3_n;
        lanes     = lane_decode(c);
        write_dec = |lanes;
        op        = OP_IDLE;
        if ((c.chip_sel1_n && !c.ctrl_addr_strobe_n) ||
            (!c.chip_sel1_n && !en_true &&
             (!c.proc_addr_strobe_n || !c.ctrl_addr_strobe_n))) begin
            op = OP_DESELECT;
        end else if (!c.chip_sel1_n && en_true &&
                     (!c.proc_addr_strobe_n || !c.ctrl_addr_strobe_n)) begin
            op = OP_BEGIN;
        end else if (c.ctrl_addr_strobe_n &&
                     (c.proc_addr_strobe_n || c.chip_sel1_n)) begin
            op = c.burst_advance_n ? OP_SUSPEND : OP_CONTINUE;
        end
    end

    logic is_write;
    assign is_write = write_dec && !(op == OP_BEGIN && !c.proc_addr_strobe_n);

    // ==========================================
    // Address register and burst counter
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [1:0]        cnt_reg, cnt_next;
    logic              active_reg, active_next;

    always_comb begin
        addr_next   = addr_reg;
        cnt_next    = cnt_reg;
        active_next = active_reg;
        if (!stall) begin
            unique case (op)
                OP_DESELECT: active_next = 1'b0;
                OP_BEGIN: begin
                    addr_next   = c.addr[ADDR_W-1:0];
                    cnt_next    = `BURST_FIRST;
                    active_next = 1'b1;
                end
                // dummy reads advance too: enable is not consulted
                OP_CONTINUE: cnt_next = cnt_reg + `BURST_STEP;
                OP_SUSPEND:  cnt_next = cnt_reg;
                OP_IDLE:     cnt_next = cnt_reg;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            addr_reg   <= `ADDR_RESET;
            cnt_reg    <= `BURST_FIRST;
            active_reg <= 1'b0;
        end else begin
            addr_reg   <= addr_next;
            cnt_reg    <= cnt_next;
            active_reg <= active_next;
        end
    end

    // order choice on the low bits
    logic [ADDR_W-1:0] cur_addr;
    assign cur_addr = {addr_next[ADDR_W-1:2],
                       burst_bits(addr_next[1:0], cnt_next, linear_mode)};

    // ==========================================
    // Access issue
    logic acc_valid;
    assign acc_valid = (op != OP_DESELECT) && (op != OP_IDLE) &&
                       (op == OP_BEGIN || active_reg);

    logic fifo_ready;
    assign stall     = acc_valid && is_write && !fifo_ready;
    assign stall_out = stall;

    mem_req_t wr_req;
    always_comb begin
        wr_req.addr    = cur_addr;
        wr_req.lane_we = lanes;
        wr_req.wdata   = dq_s2_reg;
    end

    sram_fifo #(
        .WIDTH ($bits(mem_req_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .in_valid_in   (acc_valid && is_write),
        .in_ready_out  (fifo_ready),
        .in_data_in    (wr_req),
        .out_valid_out (wr_valid_out),
        .out_ready_in  (wr_ready_in),
        .out_data_out  (wr_req_out)
    );

    // Read address goes straight to the array
    assign rd_addr_out = cur_addr;
    assign rd_en_out   = acc_valid && !is_write && !stall;

    // ==========================================
    // Read data path and driver state
    logic              rd_pend_reg, rd_pend_next;
    logic              drive_reg, drive_next;
    logic [`DATA_W-1:0] q_reg, q_next;
    logic [`DATA_W-1:0] flow_reg, flow_next;

    always_comb begin
        rd_pend_next = rd_en_out;
        // flow stage holds array data; pipelined mode adds one more register
        flow_next    = rd_pend_reg ? rd_data_in : flow_reg;
        q_next       = flow_reg;
        drive_next   = drive_reg;
        // deselect turns drivers off at once, a stage ahead of reads
        if (op == OP_DESELECT || (acc_valid && is_write)) begin
            drive_next = 1'b0;
        // reads make all lanes active, one stage later in pipeline
        end else if (flowthru_mode ? rd_en_out : rd_pend_reg) begin
            drive_next = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rd_pend_reg <= 1'b0;
            drive_reg   <= 1'b0;
            q_reg       <= '0;
            flow_reg    <= '0;
        end else begin
            rd_pend_reg <= rd_pend_next;
            drive_reg   <= drive_next;
            q_reg       <= q_next;
            flow_reg    <= flow_next;
        end
    end

    // flow-through bypasses the extra output register, a cycle sooner
    assign dq_out = flowthru_mode ? flow_reg : q_reg;

    // writes keep lanes off; enable only gates active drivers
    assign dq_oe_out = {`LANES{drive_reg && !oe_n_sync}};

    // ==========================================
    // Assertions
    property p_global_write;
        @(posedge clk_in) disable iff (sys_rst_in)
        (!c.global_write_n) |-> (lanes == 4'hf);
    endproperty
    a_global_write: assert property (p_global_write) else $error("global write lost a lane");

    property p_byte_write;
        @(posedge clk_in) disable iff (sys_rst_in)
        (c.global_write_n && c.byte_write_n) |-> !write_dec;
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("byte write off yet write");

    property p_begin_load;
        @(posedge clk_in) disable iff (sys_rst_in)
        (op == OP_BEGIN && !stall) |=> (cnt_reg == 2'h0 && addr_reg == $past(c.addr));
    endproperty
    a_begin_load: assert property (p_begin_load) else $error("burst start did not load");

    property p_advance;
        @(posedge clk_in) disable iff (sys_rst_in)
        (op == OP_CONTINUE && !stall) |=> (cnt_reg == 2'($past(cnt_reg) + 2'h1));
    endproperty
    a_advance: assert property (p_advance) else $error("counter did not advance");

    property p_suspend;
        @(posedge clk_in) disable iff (sys_rst_in)
        (op == OP_SUSPEND) |=> $stable(cnt_reg);
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend moved counter");

    property p_deselect_off;
        @(posedge clk_in) disable iff (sys_rst_in)
        (op == OP_DESELECT) |=> (dq_oe_out == 4'h0);
    endproperty
    a_deselect_off: assert property (p_deselect_off) else $error("drivers on after deselect");

    property p_write_hiz;
        @(posedge clk_in) disable iff (sys_rst_in)
        (acc_valid && is_write) |=> (dq_oe_out == 4'h0);
    endproperty
    a_write_hiz: assert property (p_write_hiz) else $error("drivers on during write");

    property p_oe_gate;
        @(posedge clk_in) disable iff (sys_rst_in)
        (oe_n_sync || !drive_reg) |-> (dq_oe_out == 4'h0);
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("output enable misgated");

    property p_linear_wrap;
        @(posedge clk_in) disable iff (sys_rst_in)
        (linear_mode && op == OP_CONTINUE && !stall) |->
        (cur_addr[1:0] == 2'(addr_reg[1:0] + cnt_reg + 2'h1));
    endproperty
    a_linear_wrap: assert property (p_linear_wrap) else $error("linear order wrong");

    property p_interleave;
        @(posedge clk_in) disable iff (sys_rst_in)
        (!linear_mode && op == OP_CONTINUE && !stall) |->
        (cur_addr[1:0] == (addr_reg[1:0] ^ 2'(cnt_reg + 2'h1)));
    endproperty
    a_interleave: assert property (p_interleave) else $error("interleaved order wrong");

    property p_read_drive;
        @(posedge clk_in) disable iff (sys_rst_in)
        (flowthru_mode && rd_en_out) |=> drive_reg;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("flow read left drivers off");

    property p_pipe_drive;
        @(posedge clk_in) disable iff (sys_rst_in)
        (!flowthru_mode && rd_pend_reg && op != OP_DESELECT && !(acc_valid && is_write)) |=> drive_reg;
    endproperty
    a_pipe_drive: assert property (p_pipe_drive) else $error("pipelined read left drivers off");

    property p_proc_read;
        @(posedge clk_in) disable iff (sys_rst_in)
        (op == OP_BEGIN && !c.proc_addr_strobe_n) |-> (rd_en_out && !is_write);
    endproperty
    a_proc_read: assert property (p_proc_read) else $error("processor strobe did not read");

    property p_begin_write;
        @(posedge clk_in) disable iff (sys_rst_in)
        (op == OP_BEGIN && c.proc_addr_strobe_n && write_dec) |-> (is_write && !rd_en_out);
    endproperty
    a_begin_write: assert property (p_begin_write) else $error("controller strobe write not issued");

    property p_desel_clear;
        @(posedge clk_in) disable iff (sys_rst_in)
        (op == OP_DESELECT) |=> !active_reg;
    endproperty
    a_desel_clear: assert property (p_desel_clear) else $error("deselect left burst active");
endmodule : sync_burst_sram_control

// >>> verilog/sram_ctrl_defines.svh
// Purpose: Constants for the synchronous burst SRAM control block
// Assumes: 32-bit data in four byte lanes, 16-bit word address
// Notes  : Definitions only
`ifndef SRAM_CTRL_DEFINES_SVH
`define SRAM_CTRL_DEFINES_SVH
`define ADDR_W        16
`define LANES         4
`define DATA_W        32
`define FIFO_DEPTH    8
`define BURST_STEP    2'h1
`define BURST_FIRST   2'h0
`define ADDR_RESET    16'h0000
`endif

// >>> verilog/sram_ctrl_pkg.sv
// Purpose: Types shared by the SRAM control block files
// Assumes: sram_ctrl_defines.svh supplies the widths
// Notes  : Packed structs carry related signals together
`include "sram_ctrl_defines.svh"
package sram_ctrl_pkg;
    // Synchronous control inputs sampled each edge
    typedef struct packed {
        logic                  chip_sel1_n;
        logic                  chip_sel2;
        logic                  chip_sel3_n;
        logic                  proc_addr_strobe_n;
        logic                  ctrl_addr_strobe_n;
        logic                  burst_advance_n;
        logic                  global_write_n;
        logic                  byte_write_n;
        logic [`LANES-1:0]     lane_write_n;
        logic [`ADDR_W-1:0]    addr;
    } ctrl_in_t;
    // Memory access request toward the array
    typedef struct packed {
        logic [`ADDR_W-1:0]    addr;
        logic [`LANES-1:0]     lane_we;
        logic [`DATA_W-1:0]    wdata;
    } mem_req_t;
    // Decoded cycle kind
    typedef enum logic [2:0] {
        OP_DESELECT = 3'b000,
        OP_IDLE     = 3'b001,
        OP_BEGIN    = 3'b010,
        OP_CONTINUE = 3'b011,
        OP_SUSPEND  = 3'b100
    } op_t;
endpackage : sram_ctrl_pkg

// >>> verilog/sram_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes  : Flip-flop storage; depth must be a power of two
`timescale 1ns/1ps
module sram_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [AW:0]      count_reg, count_next;
    logic             push, pop;

    // ==========================================
    // Pointer and count update
    always_comb begin
        push        = in_valid_in && in_ready_out;
        pop         = out_valid_out && out_ready_in;
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    // Storage written only on push; no reset needed on data
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

    // Honest full and empty flags
    assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_out = (count_reg != '0);
    assign out_data_out  = mem_reg[rd_ptr_reg];
endmodule : sram_fifo

// >>> verification/array_model.sv
// Purpose: Behavioural storage array behind the SRAM control block
// Assumes: Read data is wanted one cycle after the read strobe
// Notes  : Unwritten words hold an address pattern; hold_in stalls the write queue
`timescale 1ns/1ps
module array_model (
    // Clock and bench control
    input  wire logic                    clk_in,
    input  wire logic                    hold_in,
    // Write queue side
    input  wire logic                    wr_valid_in,
    output logic                         wr_ready_out,
    input  wire sram_ctrl_pkg::mem_req_t wr_req_in,
    // Read side
    input  wire logic [15:0]             rd_addr_in,
    input  wire logic                    rd_en_in,
    output logic [31:0]                  rd_data_out
);
    import sram_ctrl_pkg::*;
    logic [31:0] mem_reg [logic [15:0]];
    // ==========================================
    // Queue acceptance
    // Holding off acceptance is the only way the bench can fill the write buffer
    assign wr_ready_out = ~hold_in;
    // Lane merge on accepted writes; a bus with no read toggles so stale data never passes
    initial rd_data_out = 32'h0;
    always @(posedge clk_in) begin : upd
        logic [31:0] w;
        if (wr_valid_in && wr_ready_out) begin
            w = mem_reg.exists(wr_req_in.addr) ? mem_reg[wr_req_in.addr] : {wr_req_in.addr ^ 16'h5a5a, wr_req_in.addr};
            for (int l = 0; l < 4; l++) if (wr_req_in.lane_we[l]) w[8*l+:8] = wr_req_in.wdata[8*l+:8];
            mem_reg[wr_req_in.addr] = w;
        end
        if (rd_en_in) rd_data_out <= mem_reg.exists(rd_addr_in) ? mem_reg[rd_addr_in] : {rd_addr_in ^ 16'h5a5a, rd_addr_in};
        else rd_data_out <= ~rd_data_out;
    end
endmodule : array_model

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the sync burst SRAM control block
// Assumes: Control reaches the decode two edges after it is driven
// Notes  : Idle cycles are deselects so that no burst lingers between scenarios
`timescale 1ns/1ps
module tb_top;
    import sram_ctrl_pkg::*;
    // Flag codes {chip_sel1_n,chip_sel2,chip_sel3_n,proc,ctrl,adv,global_wr,byte_wr}
    localparam logic [7:0] c_rd = 8'h57, c_cont = 8'h5b, c_susp = 8'h5f, c_wrg = 8'h55;
    localparam logic [7:0] c_wrb = 8'h56, c_idle = 8'hb7, c_prd = 8'h4e, c_cwr = 8'h59;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    ctrl_in_t    ctrl = {c_idle, 4'hf, 16'h0};
    logic        lin_n = 1'b0, ft_n = 1'b1, oe_n = 1'b0, hold = 1'b0;
    logic        lin_nx = 1'b0, ft_nx = 1'b1, oe_nx = 1'b0, oe_seen = 1'b0, st_seen = 1'b0;
    logic        wr_ready, rd_en, wr_valid, stall;
    logic [31:0] dq_i = 32'h0, dq_o, rd_data;
    logic [3:0]  dq_oe;
    logic [15:0] rd_addr;
    mem_req_t    wr_req;
    logic [15:0] rq [$];
    mem_req_t    wq [$];
    int          err_count = 0, num_checks = 0, cyc_cnt = 0, lf, df, lp, dp;

    sync_burst_sram_control u_dut (.clk_in(clk), .sys_rst_in(rst), .ctrl_in(ctrl), .linear_order_n_in(lin_n),
        .flowthru_sel_n_in(ft_n), .output_en_n_in(oe_n), .dq_in(dq_i), .dq_out(dq_o), .dq_oe_out(dq_oe),
        .wr_valid_out(wr_valid), .wr_ready_in(wr_ready), .wr_req_out(wr_req), .rd_addr_out(rd_addr),
        .rd_en_out(rd_en), .rd_data_in(rd_data), .stall_out(stall));
    array_model u_array (.clk_in(clk), .hold_in(hold), .wr_valid_in(wr_valid), .wr_ready_out(wr_ready),
        .wr_req_in(wr_req), .rd_addr_in(rd_addr), .rd_en_in(rd_en), .rd_data_out(rd_data));

    // ==========================================
    // Clock, monitor and hang guard
    always #2.5 clk = ~clk;
    // Sampled before the edge's own updates land, so every value seen is settled
    always @(posedge clk) begin
        cyc_cnt++;
        if (rd_en === 1'b1) rq.push_back(rd_addr);
        if (wr_valid === 1'b1 && wr_ready) wq.push_back(wr_req);
        if (dq_oe !== 4'h0) oe_seen = 1'b1;
        if (stall === 1'b1) st_seen = 1'b1;
        if (cyc_cnt == 4000) begin
            err_count++;
            $display("ERROR t=%0t run did not finish", $time);
            final_report();
        end
    end

    // ==========================================
    // Shared tasks
    function automatic ctrl_in_t mk(input logic [7:0] f, input logic [3:0] ln, input logic [15:0] a);
        mk = {f, ln, a};
    endfunction : mk
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic cyc(input ctrl_in_t c, input logic [31:0] d);
        @(posedge clk);
        ctrl <= c;
        dq_i <= d;
        lin_n <= lin_nx;
        ft_n <= ft_nx;
        oe_n <= oe_nx;
        @(negedge clk);
    endtask : cyc
    // Data pins toggle when nothing is written so a stale value is never taken
    task automatic cycn(input ctrl_in_t c);
        cyc(c, ~dq_i);
    endtask : cycn
    task automatic idle(input int n);
        repeat (n) cycn(mk(c_idle, 4'hf, 16'h0));
    endtask : idle
    task automatic begin_t(input logic l, input logic f, input logic o);
        lin_nx = l;
        ft_nx = f;
        oe_nx = o;
        idle(4);
        rq.delete();
        wq.delete();
        oe_seen = 1'b0;
        st_seen = 1'b0;
    endtask : begin_t

    // ==========================================
    // Scenarios
    task automatic t_burst(input logic l_n, input logic [15:0] a, input logic [7:0] seq);
        begin_t(l_n, 1'b1, 1'b0);
        cycn(mk(c_rd, 4'hf, a));
        repeat (4) cycn(mk(c_cont, 4'hf, 16'h0));
        idle(6);
        chk(rq.size(), 5, "burst length");
        for (int i = 0; i < 5; i++) chk(rq[i], {a[15:2], seq[2*(i%4)+:2]}, "burst address");
    endtask : t_burst
    task automatic t_susp();
        begin_t(1'b0, 1'b1, 1'b0);
        cycn(mk(c_prd, 4'h0, 16'h0402));
        repeat (2) cycn(mk(c_susp, 4'hf, 16'h0));
        cycn(mk(c_cont, 4'hf, 16'h0));
        idle(6);
        chk(wq.size(), 0, "processor strobe wrote");
        chk(rq.size(), 4, "suspend reads");
        for (int i = 0; i < 4; i++) chk(rq[i], (i == 3) ? 16'h0403 : 16'h0402, "suspend address");
    endtask : t_susp
    task automatic t_write();
        logic [3:0]  ln [6] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h5, 4'h0};
        logic [15:0] ea;
        logic [3:0]  el;
        begin_t(1'b0, 1'b1, 1'b0);
        cyc(mk(c_wrg, 4'ha, 16'h0100), 32'hc0de0000);
        foreach (ln[i]) cyc(mk(c_wrb, ln[i], 16'h0110 + 16'(i)), 32'hc0de0001 + 32'(i));
        idle(4);
        chk(oe_seen, 1'b0, "drivers on in write");
        cycn(mk(c_wrb, 4'hf, 16'h0120));
        cyc(mk(c_cwr, 4'hf, 16'h0), 32'hc0de0007);
        idle(6);
        chk(rq.size(), 1, "no-lane read count");
        chk(rq[0], 16'h0120, "no-lane read address");
        chk(wq.size(), 8, "write count");
        for (int i = 0; i < 8; i++) begin
            ea = (i == 0) ? 16'h0100 : (i == 7) ? 16'h0121 : 16'h010f + 16'(i);
            el = (i == 0 || i == 7) ? 4'hf : ~ln[(i > 0) ? i - 1 : 0];
            chk(wq[i].addr, ea, "write address");
            chk(wq[i].lane_we, el, "write lanes");
            chk(wq[i].wdata, 32'hc0de0000 + 32'(i), "write data");
        end
    endtask : t_write
    task automatic t_desel();
        logic [7:0] dc [3] = '{8'hb7, 8'h0f, 8'h77};
        begin_t(1'b0, 1'b1, 1'b0);
        foreach (dc[k]) begin
            rq.delete();
            cycn(mk(c_rd, 4'hf, 16'h0500));
            cycn(mk(c_susp, 4'hf, 16'h0));
            cycn(mk(dc[k], 4'hf, 16'h0500));
            repeat (2) cycn(mk(c_cont, 4'hf, 16'h0));
            idle(6);
            chk(rq.size(), 2, "reads past deselect");
            chk(dq_oe, 4'h0, "drivers after deselect");
        end
    endtask : t_desel
    task automatic t_dummy();
        begin_t(1'b0, 1'b1, 1'b1);
        cycn(mk(c_rd, 4'hf, 16'h0300));
        repeat (3) cycn(mk(c_cont, 4'hf, 16'h0));
        // Drivers held off throughout, so the bus turns to writing without a deselect
        cyc(mk(c_cwr, 4'hf, 16'h0), 32'h0dd00001);
        idle(6);
        chk(rq.size(), 4, "dummy read count");
        for (int i = 0; i < 4; i++) chk(rq[i], 16'h0300 + 16'(i), "dummy read address");
        chk(wq[0].addr, 16'h0300, "turnaround write address");
        chk(oe_seen, 1'b0, "drivers with enable high");
    endtask : t_dummy
    task automatic t_fifo();
        begin_t(1'b0, 1'b1, 1'b0);
        hold = 1'b1;
        // Every cycle drives a new address through the controller strobe; the ninth stalls on the full queue and loads nothing
        for (int i = 0; i < 9; i++) cyc(mk(c_wrg, 4'hf, 16'h0400 + 16'(i)), 32'hf1f00000 + 32'(i));
        idle(4);
        chk(st_seen, 1'b1, "stall when full");
        chk(wr_valid, 1'b1, "queue holds writes");
        chk(wq.size(), 0, "accepted while held");
        hold = 1'b0;
        idle(14);
        chk(wr_valid, 1'b0, "queue drained");
        chk(wq.size(), 8, "drained count");
        for (int i = 0; i < 8; i++) chk(wq[i].addr, 16'h0400 + 16'(i), "queued address");
    endtask : t_fifo
    task automatic t_read(input logic f, input logic [15:0] a, output int lat, output int dl);
        begin_t(1'b0, f, 1'b0);
        cycn(mk(c_rd, 4'hf, a));
        lat = 0;
        for (int i = 1; i <= 6; i++) begin
            cycn(mk(c_susp, 4'hf, 16'h0));
            if (lat == 0 && dq_o === {a ^ 16'h5a5a, a}) lat = i;
        end
        chk(dq_oe, 4'hf, "all lanes drive on read");
        oe_nx = 1'b1;
        repeat (4) cycn(mk(c_susp, 4'hf, 16'h0));
        chk(dq_oe, 4'h0, "enable high turns drivers off");
        oe_nx = 1'b0;
        repeat (4) cycn(mk(c_susp, 4'hf, 16'h0));
        chk(dq_oe, 4'hf, "enable low restores drivers");
        idle(1);
        dl = 0;
        for (int i = 1; i <= 6; i++) begin
            idle(1);
            if (dl == 0 && dq_oe === 4'h0) dl = i;
        end
    endtask : t_read

    // ==========================================
    // Main sequence and verdict
    task automatic final_report();
        $display("Checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_burst(1'b0, 16'h1231, 8'h39);
        t_burst(1'b0, 16'hbeef, 8'h93);
        t_burst(1'b1, 16'h1231, 8'hb1);
        t_burst(1'b1, 16'h7a52, 8'h4e);
        t_susp();
        t_write();
        t_desel();
        t_dummy();
        t_fifo();
        t_read(1'b0, 16'h0200, lf, df);
        t_read(1'b1, 16'h0208, lp, dp);
        chk(lp, lf + 1, "pipelined read one cycle later");
        chk(dp < lp, 1'b1, "deselect quicker than read");
        final_report();
    end
endmodule : tb_top
